// file: shared/adc_scan_event_control_regs.vh
// register offsets, field positions, reset values and timing counts of the scan control block
`ifndef ADC_SCAN_EVENT_CONTROL_REGS_VH
`define ADC_SCAN_EVENT_CONTROL_REGS_VH

// byte addresses of the word registers
`define REG_CTRL_OFS        6'h00
`define REG_TRIG_OFS        6'h04
`define REG_CONV_OFS        6'h08
`define REG_EXT_OFS         6'h0c
`define REG_CMP_CHAN_OFS    6'h10
`define REG_CMP_LEVEL_OFS   6'h14
`define REG_CMP_STATUS_OFS  6'h18
`define REG_GRP_PRIO_OFS    6'h1c
`define REG_DISC_OFS        6'h20
`define REG_RESULT_OFS      6'h24
`define REG_DUP_OFS         6'h28
`define REG_DUP_A_OFS       6'h2c
`define REG_DUP_B_OFS       6'h30
`define REG_DIAG_OFS        6'h34
`define REG_STATUS_OFS      6'h38

// control register fields
`define CTRL_DBL_CHAN_LSB   0
`define CTRL_GRP_B_IE_BIT   6
`define CTRL_DBL_EN_BIT     7
`define CTRL_HW_TRIG_EN_BIT 9
`define CTRL_SCAN_IE_BIT    12
`define CTRL_MODE_LSB       13
`define CTRL_START_BIT      15
`define CTRL_CMP_IE_BIT     16
`define CTRL_EVT_EN_BIT     17

// trigger select fields
`define TRIG_B_LSB          0
`define TRIG_A_LSB          8

// conversion setup fields
`define CONV_PREC_LSB       1
`define CONV_AUTOCLR_BIT    5
`define CONV_DIAG_VOLT_LSB  8
`define CONV_DIAG_MODE_BIT  10
`define CONV_DIAG_EN_BIT    11
`define CONV_AVG_BIT        16

// extended input fields
`define EXT_TS_A_BIT        0
`define EXT_REF_A_BIT       1
`define EXT_TS_B_BIT        2
`define EXT_REF_B_BIT       3
`define EXT_SEL_LSB         8
`define EXT_OUT_BIT         10

// scan modes
`define MODE_SINGLE         2'h0
`define MODE_GROUP          2'h1
`define MODE_CONT           2'h2

// precision codes
`define PREC_12             2'h0
`define PREC_10             2'h1
`define PREC_8              2'h2

// trigger source codes
`define TRIG_SRC_PIN        6'h00
`define TRIG_SRC_LINK       6'h01

`define CTRL_RESET          32'h0000_0000
`define CONV_TIME_NS        500
`define CLK_PERIOD_NS       50
// conversion count: 500 ns at the 50 ns core clock, sized for the counter
`define CONV_CYCLES         5'h0a

`endif

// file: rtl/adc_scan_event_control.v
// scan sequencing, trigger selection, duplication, compare and request logic
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_event_control_regs.vh"

module adc_scan_event_control (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        ext_trigger_n_i,
  input  wire        link_trigger_i,
  input  wire [11:0] sample_data_i,
  output reg         scan_end_irq_o,
  output reg         group_b_scan_end_irq_o,
  output reg         compare_match_irq_o,
  output reg         event_link_o,
  output reg         dma_request_o,
  output wire [1:0]  ext_input_sel_o,
  output wire        ext_output_ctrl_o,
  output wire        temp_sensor_sel_o,
  output wire        ref_voltage_sel_o,
  output wire [7:0]  disconnect_detect_ctrl_o,
  output wire        busy_o
);

  // ****************************************************************
  // states and register storage
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV_A = 2'h1;
  localparam [1:0] ST_CONV_B = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg [31:0] ctrl_ff;
  reg [31:0] trig_ff;
  reg [31:0] conv_ff;
  reg [31:0] ext_ff;
  reg [4:0]  cmp_chan_ff;
  reg [11:0] cmp_level_ff;
  reg        cmp_status_ff;
  reg [1:0]  grp_prio_ff;
  reg [7:0]  disc_ff;
  reg [13:0] result_ff;
  reg [13:0] dup_ff;
  reg [13:0] dup_a_ff;
  reg [13:0] dup_b_ff;
  reg [13:0] diag_ff;
  reg [1:0]  state_ff;
  reg [4:0]  cnt_ff;
  reg        a_count_ff;
  reg        dbl_second_ff;
  reg        rescan_b_ff;
  reg [2:0]  pin_sync_ff;
  reg        pin_level_ff;
  reg        link_prev_ff;
  reg        ack_ff;

  wire [1:0] mode     = ctrl_ff[`CTRL_MODE_LSB +: 2];
  wire [4:0] dbl_chan = ctrl_ff[`CTRL_DBL_CHAN_LSB +: 5];
  wire       dbl_en   = ctrl_ff[`CTRL_DBL_EN_BIT];
  wire       hw_en    = ctrl_ff[`CTRL_HW_TRIG_EN_BIT];
  wire [5:0] trig_a   = trig_ff[`TRIG_A_LSB +: 6];
  wire [5:0] trig_b   = trig_ff[`TRIG_B_LSB +: 6];
  wire [1:0] prec     = conv_ff[`CONV_PREC_LSB +: 2];
  wire       in_group_b = (state_ff == ST_CONV_B);
  wire       conv_done  = (state_ff == ST_CONV_A || state_ff == ST_CONV_B) &&
                          (cnt_ff == 5'h00);

  // ****************************************************************
  // trigger sources
  // ****************************************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_sync_ff <= 3'h7;
      pin_level_ff <= 1'b1;
      link_prev_ff <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], ext_trigger_n_i};
      if (pin_sync_ff[1] == pin_sync_ff[2])
        pin_level_ff <= pin_sync_ff[2];
      link_prev_ff <= link_trigger_i;
    end
  end

  wire pin_fall  = pin_level_ff && (pin_sync_ff[1] == pin_sync_ff[2]) && !pin_sync_ff[2];
  wire link_rise = link_trigger_i && !link_prev_ff;

  function src_hit;
    input [5:0] sel;
    begin
      src_hit = (sel == `TRIG_SRC_PIN && pin_fall) || (sel == `TRIG_SRC_LINK && link_rise);
    end
  endfunction

  wire trig_a_hit = hw_en && src_hit(trig_a);
  wire trig_b_hit = hw_en && (mode == `MODE_GROUP) && src_hit(trig_b);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // writes land on the edge that ends the cycle without wait
  wire wr = avs_write_i && ack_ff;
  // read data is fetched in the wait cycle so it stands when accepted
  wire rd = avs_read_i && !ack_ff;
  wire rd_done = avs_read_i && ack_ff;
  // one wait cycle per request
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
  wire sw_start = wr && (avs_address_i == `REG_CTRL_OFS) && avs_byteenable_i[1] &&
                  avs_writedata_i[`CTRL_START_BIT];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k]) merge[k*8 +: 8] = d[k*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // conversion result shaping
  // ****************************************************************
  // precision, 12/10/8 bit
  wire [13:0] sample_shaped = (prec == `PREC_10) ? {4'h0, sample_data_i[11:2]} :
                              (prec == `PREC_8)  ? {6'h0, sample_data_i[11:4]} :
                                                   {2'h0, sample_data_i};
  // diagnosis substitutes a fixed test level
  wire [13:0] diag_level = {2'h0, conv_ff[`CONV_DIAG_VOLT_LSB +: 2], 10'h000};
  wire        diag_on    = conv_ff[`CONV_DIAG_EN_BIT];
  wire [13:0] sample_val = diag_on ? diag_level : sample_shaped;
  wire [13:0] summed   = result_ff + sample_val;
  wire [13:0] combined = conv_ff[`CONV_AVG_BIT] ? {1'b0, summed[13:1]} : summed;
  wire        cmp_hit  = conv_done && (dbl_chan == cmp_chan_ff) &&
                         (sample_val[11:0] >= cmp_level_ff);

  // ****************************************************************
  // scan sequencer
  // ****************************************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
      a_count_ff <= 1'b0;
      dbl_second_ff <= 1'b0;
      rescan_b_ff <= 1'b0;
      scan_end_irq_o <= 1'b0;
      group_b_scan_end_irq_o <= 1'b0;
      compare_match_irq_o <= 1'b0;
      event_link_o <= 1'b0;
      dma_request_o <= 1'b0;
      result_ff <= 14'h0000;
      dup_ff <= 14'h0000;
      dup_a_ff <= 14'h0000;
      dup_b_ff <= 14'h0000;
      diag_ff <= 14'h0000;
      cmp_status_ff <= 1'b0;
    end else begin
      scan_end_irq_o <= 1'b0;
      group_b_scan_end_irq_o <= 1'b0;
      compare_match_irq_o <= 1'b0;
      event_link_o <= 1'b0;
      dma_request_o <= 1'b0;
      if (rd_done && avs_address_i == `REG_RESULT_OFS && conv_ff[`CONV_AUTOCLR_BIT])
        result_ff <= 14'h0000;
      if (wr && avs_address_i == `REG_CMP_STATUS_OFS && avs_writedata_i[0])
        cmp_status_ff <= 1'b0;
      // compare request, set wins over clear
      if (cmp_hit) begin
        cmp_status_ff <= 1'b1;
        compare_match_irq_o <= ctrl_ff[`CTRL_CMP_IE_BIT];
      end
      // group A priority aborts group B
      if (in_group_b && trig_a_hit && grp_prio_ff[0]) begin
        rescan_b_ff <= grp_prio_ff[1];
        state_ff <= ST_CONV_A;
        cnt_ff <= `CONV_CYCLES;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (sw_start || trig_a_hit) begin
              state_ff <= ST_CONV_A;
              cnt_ff <= `CONV_CYCLES;
            end else if (trig_b_hit || rescan_b_ff) begin
              rescan_b_ff <= 1'b0;
              state_ff <= ST_CONV_B;
              cnt_ff <= `CONV_CYCLES;
            end
          end
          ST_CONV_A, ST_CONV_B: begin
            if (cnt_ff != 5'h00)
              cnt_ff <= cnt_ff - 5'h01;
            else begin
              if (diag_on)
                diag_ff <= sample_val;
              // first to result, second to duplicate; per-group copies
              else if (dbl_en && dbl_second_ff) begin
                dup_ff <= sample_val;
                if (in_group_b) dup_b_ff <= sample_val;
                else dup_a_ff <= sample_val;
              end else if (conv_ff[`CONV_AVG_BIT] && result_ff != 14'h0000)
                result_ff <= combined;
              else
                result_ff <= sample_val;
              if (dbl_en && !in_group_b)
                dbl_second_ff <= !dbl_second_ff;
              state_ff <= ST_DONE;
            end
          end
          // one settle cycle before the next trigger is taken
          ST_DONE: begin
            state_ff <= ST_IDLE;
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
      // requests on completion
      if (conv_done) begin
        if (in_group_b) begin
          // group B request, own enable, pulse
          group_b_scan_end_irq_o <= ctrl_ff[`CTRL_GRP_B_IE_BIT];
          dma_request_o <= ctrl_ff[`CTRL_GRP_B_IE_BIT];
        end else begin
          event_link_o <= ctrl_ff[`CTRL_EVT_EN_BIT];
          // double trigger counts two A scans, except in continuous mode
          if (dbl_en && mode != `MODE_CONT) begin
            a_count_ff <= !a_count_ff;
            if (a_count_ff) begin
              scan_end_irq_o <= ctrl_ff[`CTRL_SCAN_IE_BIT];
              dma_request_o <= ctrl_ff[`CTRL_SCAN_IE_BIT];
            end
          end else begin
            scan_end_irq_o <= ctrl_ff[`CTRL_SCAN_IE_BIT];
            dma_request_o <= ctrl_ff[`CTRL_SCAN_IE_BIT];
          end
        end
      end
      if (state_ff == ST_DONE && mode == `MODE_CONT && !in_group_b) begin
        state_ff <= ST_CONV_A;
        cnt_ff <= `CONV_CYCLES;
      end
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= `CTRL_RESET;
      trig_ff <= 32'h0000_0000;
      conv_ff <= 32'h0000_0000;
      ext_ff <= 32'h0000_0000;
      cmp_chan_ff <= 5'h00;
      cmp_level_ff <= 12'h000;
      grp_prio_ff <= 2'h0;
      disc_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else begin
      // ack marks the accepting cycle of every request
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
      if (wr) begin
        case (avs_address_i)
          `REG_CTRL_OFS: ctrl_ff <= merge(ctrl_ff, avs_writedata_i, avs_byteenable_i) &
                                    ~(32'h1 << `CTRL_START_BIT);
          `REG_TRIG_OFS: trig_ff <= merge(trig_ff, avs_writedata_i, avs_byteenable_i);
          `REG_CONV_OFS: conv_ff <= merge(conv_ff, avs_writedata_i, avs_byteenable_i);
          `REG_EXT_OFS: ext_ff <= merge(ext_ff, avs_writedata_i, avs_byteenable_i);
          `REG_CMP_CHAN_OFS: cmp_chan_ff <= avs_writedata_i[4:0];
          `REG_CMP_LEVEL_OFS: cmp_level_ff <= avs_writedata_i[11:0];
          `REG_GRP_PRIO_OFS: grp_prio_ff <= avs_writedata_i[1:0];
          `REG_DISC_OFS: disc_ff <= avs_writedata_i[7:0];
          // unmapped writes are dropped
          default: ack_ff <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (rd) begin
      case (avs_address_i)
        `REG_CTRL_OFS:       avs_readdata_o <= ctrl_ff;
        `REG_TRIG_OFS:       avs_readdata_o <= trig_ff;
        `REG_CONV_OFS:       avs_readdata_o <= conv_ff;
        `REG_EXT_OFS:        avs_readdata_o <= ext_ff;
        `REG_CMP_CHAN_OFS:   avs_readdata_o <= {27'h0, cmp_chan_ff};
        `REG_CMP_LEVEL_OFS:  avs_readdata_o <= {20'h0, cmp_level_ff};
        `REG_CMP_STATUS_OFS: avs_readdata_o <= {31'h0, cmp_status_ff};
        `REG_GRP_PRIO_OFS:   avs_readdata_o <= {30'h0, grp_prio_ff};
        `REG_DISC_OFS:       avs_readdata_o <= {24'h0, disc_ff};
        `REG_RESULT_OFS:     avs_readdata_o <= {18'h0, result_ff};
        `REG_DUP_OFS:        avs_readdata_o <= {18'h0, dup_ff};
        `REG_DUP_A_OFS:      avs_readdata_o <= {18'h0, dup_a_ff};
        `REG_DUP_B_OFS:      avs_readdata_o <= {18'h0, dup_b_ff};
        `REG_DIAG_OFS:       avs_readdata_o <= {18'h0, diag_ff};
        `REG_STATUS_OFS:     avs_readdata_o <= {28'h0, a_count_ff, rescan_b_ff, state_ff};
        default:             avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // analog side controls
  // ****************************************************************
  // sensor and reference per active group
  assign temp_sensor_sel_o = in_group_b ? ext_ff[`EXT_TS_B_BIT] : ext_ff[`EXT_TS_A_BIT];
  assign ref_voltage_sel_o = in_group_b ? ext_ff[`EXT_REF_B_BIT] : ext_ff[`EXT_REF_A_BIT];
  assign ext_input_sel_o = ext_ff[`EXT_SEL_LSB +: 2];
  assign ext_output_ctrl_o = ext_ff[`EXT_OUT_BIT];
  assign disconnect_detect_ctrl_o = disc_ff;
  // busy covers conversion and the settle cycle
  assign busy_o = (state_ff != ST_IDLE);

endmodule // adc_scan_event_control
`default_nettype wire

// file: tb/adc_scan_event_control_props.sv
// concurrent checks on the scan control block ports
`timescale 1ns/100ps
`default_nettype none
module adc_scan_event_control_props (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic scan_end_irq_o,
  input wire logic group_b_scan_end_irq_o,
  input wire logic compare_match_irq_o,
  input wire logic event_link_o,
  input wire logic dma_request_o,
  input wire logic busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_scan_irq_pulse: assert property (scan_end_irq_o |=> !scan_end_irq_o)
    else $error("scan end request longer than one cycle");
  a_grpb_irq_pulse: assert property (group_b_scan_end_irq_o |=> !group_b_scan_end_irq_o)
    else $error("group b request longer than one cycle");
  a_cmp_irq_pulse: assert property (compare_match_irq_o |=> !compare_match_irq_o)
    else $error("compare request longer than one cycle");
  a_event_pulse: assert property (event_link_o |=> !event_link_o)
    else $error("link event longer than one cycle");
  a_grpb_no_event: assert property (group_b_scan_end_irq_o |-> !event_link_o)
    else $error("link event on group b end");
  a_scan_after_busy: assert property (scan_end_irq_o |-> $past(busy_o, 2))
    else $error("scan end request without a scan");
  a_grpb_after_busy: assert property (group_b_scan_end_irq_o |-> $past(busy_o, 2))
    else $error("group b request without a scan");
  a_no_early_end: assert property ($rose(busy_o) |-> !scan_end_irq_o [*8])
    else $error("scan end request too early");
  a_one_wait_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  a_wait_on_new: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle on new request");
  a_idle_no_wait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait without request");
  a_dma_follows_end: assert property (dma_request_o == (scan_end_irq_o || group_b_scan_end_irq_o))
    else $error("transfer request not tied to a scan end request");
endmodule // adc_scan_event_control_props
bind adc_scan_event_control adc_scan_event_control_props i_adc_scan_event_control_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .scan_end_irq_o(scan_end_irq_o), .group_b_scan_end_irq_o(group_b_scan_end_irq_o),
  .compare_match_irq_o(compare_match_irq_o), .event_link_o(event_link_o),
  .dma_request_o(dma_request_o), .busy_o(busy_o));
`default_nettype wire

// file: tb/trigger_source_model.sv
// trigger pin, link trigger and converter sample model of the far side
`timescale 1ns/100ps
`default_nettype none
module trigger_source_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        fire_link_i,
  input  wire logic        fire_pin_i,
  input  wire logic [11:0] sample_val_i,
  output var  logic        link_trigger_o,
  output var  logic        ext_trigger_n_o,
  output var  logic [11:0] sample_data_o
);
  logic [2:0] link_ff;
  logic [2:0] pin_ff;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_ff <= 3'h0;
      pin_ff <= 3'h0;
    end else begin
      link_ff <= fire_link_i ? 3'h2 : (link_ff != 3'h0 ? link_ff - 3'h1 : 3'h0);
      pin_ff <= fire_pin_i ? 3'h6 : (pin_ff != 3'h0 ? pin_ff - 3'h1 : 3'h0);
    end
  end
  // pin idles high by its pull-up
  always @(posedge clk_i) begin
    link_trigger_o <= (link_ff != 3'h0);
    ext_trigger_n_o <= (pin_ff == 3'h0);
    sample_data_o <= sample_val_i;
  end
endmodule // trigger_source_model
`default_nettype wire

// file: tb/adc_scan_event_control_tb.sv
// self-checking bench of the scan control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_event_control_regs.vh"
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, s); end end
module adc_scan_event_control_tb;
  logic        core_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        fire_link = 1'b0;
  logic        fire_pin = 1'b0;
  logic [11:0] sample_val = 12'h0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, ext_trigger_n, link_trigger, busy_o;
  wire  [11:0] sample_data;
  wire         scan_irq, grpb_irq, cmp_irq, evt_o, dma_o, ext_out, ts_sel, ref_sel;
  wire  [1:0]  ext_sel;
  wire  [7:0]  disc_o;
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 82373;
  int          irq_q[$];
  logic [31:0] rd_q[$];
  logic [31:0] v;
  logic [11:0] s;
  localparam logic [31:0] SCAN_IE = 32'h1 << `CTRL_SCAN_IE_BIT;
  localparam logic [31:0] GRPB_IE = 32'h1 << `CTRL_GRP_B_IE_BIT;
  localparam logic [31:0] CMP_IE = 32'h1 << `CTRL_CMP_IE_BIT;
  localparam logic [31:0] EVT_EN = 32'h1 << `CTRL_EVT_EN_BIT;
  localparam logic [31:0] HW_EN = 32'h1 << `CTRL_HW_TRIG_EN_BIT;
  localparam logic [31:0] DBL_EN = 32'h1 << `CTRL_DBL_EN_BIT;
  localparam logic [31:0] START = 32'h1 << `CTRL_START_BIT;
  localparam logic [31:0] GROUP = 32'h1 << `CTRL_MODE_LSB;
  adc_scan_event_control i_adc_scan_event_control (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_trigger_n_i(ext_trigger_n),
    .link_trigger_i(link_trigger), .sample_data_i(sample_data), .scan_end_irq_o(scan_irq),
    .group_b_scan_end_irq_o(grpb_irq), .compare_match_irq_o(cmp_irq), .event_link_o(evt_o),
    .dma_request_o(dma_o), .ext_input_sel_o(ext_sel), .ext_output_ctrl_o(ext_out),
    .temp_sensor_sel_o(ts_sel), .ref_voltage_sel_o(ref_sel),
    .disconnect_detect_ctrl_o(disc_o), .busy_o(busy_o));
  trigger_source_model i_trigger_source_model (
    .clk_i(core_clk_i), .nrst_i(nrst_i), .fire_link_i(fire_link), .fire_pin_i(fire_pin),
    .sample_val_i(sample_val), .link_trigger_o(link_trigger),
    .ext_trigger_n_o(ext_trigger_n), .sample_data_o(sample_data));
  always #25 core_clk_i = ~core_clk_i;
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic kick(input logic pin);
    fire_pin <= pin;
    fire_link <= !pin;
    @(posedge core_clk_i);
    fire_pin <= 1'b0;
    fire_link <= 1'b0;
  endtask
  task automatic wait_scan;
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 40) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK("scan running", 1'b1, busy_o)
    while (busy_o !== 1'b0 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK("scan finished", 1'b0, busy_o)
    repeat (3) @(posedge core_clk_i);
    `CHK("pending requests", 0, irq_q.size())
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ************************************************
  // monitor: each pulse or read takes its oldest note
  // ************************************************
  always @(posedge core_clk_i) begin
    logic [3:0] pul;
    int hit;
    if (nrst_i === 1'b1) begin
      pul = {evt_o, cmp_irq, grpb_irq, scan_irq};
      for (int k = 0; k < 4; k++) begin
        if (pul[k] !== 1'b0) begin
          hit = -1;
          foreach (irq_q[i]) begin
            if (irq_q[i] == k && hit < 0) hit = i;
          end
          `CHK("request id", k, (hit < 0) ? 9 : irq_q[hit])
          if (hit >= 0) irq_q.delete(hit);
        end
      end
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
        `CHK("read data", rd_q[0], avs_readdata_o)
        void'(rd_q.pop_front());
      end
    end
  end
  initial begin
    #(20000 * 50);
    num_errors++;
    wrap_up;
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`REG_CTRL_OFS, `CTRL_RESET);
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    rd(6'h3c, 32'h0);
    v = {18'h0, `TRIG_SRC_LINK, 2'h0, `TRIG_SRC_PIN};
    bus(1'b1, `REG_TRIG_OFS, v);
    rd(`REG_TRIG_OFS, v);
    for (int p = 0; p < 3; p++) begin
      v = 32'h0;
      v[`CONV_PREC_LSB +: 2] = 2'(p);
      v[`CONV_DIAG_VOLT_LSB +: 2] = 2'($random(seed));
      v[`CONV_DIAG_MODE_BIT] = 1'($random(seed));
      v[`CONV_DIAG_EN_BIT] = 1'($random(seed));
      v[`CONV_AVG_BIT] = 1'($random(seed));
      bus(1'b1, `REG_CONV_OFS, v);
      rd(`REG_CONV_OFS, v);
    end
    avs_byteenable_i <= 4'h2;
    bus(1'b1, `REG_CONV_OFS, 32'hffff_ffff);
    avs_byteenable_i <= 4'hf;
    rd(`REG_CONV_OFS, v | 32'h0000_ff00);
    bus(1'b1, `REG_CONV_OFS, 32'h0);
    v = 32'($random(seed)) & 32'h0000_070f;
    bus(1'b1, `REG_EXT_OFS, v);
    rd(`REG_EXT_OFS, v);
    `CHK("ext select", v[9:8], ext_sel)
    `CHK("ext output", v[10], ext_out)
    `CHK("sensor select", v[0], ts_sel)
    `CHK("reference select", v[1], ref_sel)
    v = 32'($random(seed)) & 32'h0000_00ff;
    bus(1'b1, `REG_DISC_OFS, v);
    `CHK("disconnect ctrl", v[7:0], disc_o)
    bus(1'b1, `REG_CMP_CHAN_OFS, 32'h3);
    for (int i = 0; i < 2; i++) begin
      s = 12'($random(seed)) & 12'h7ff;
      sample_val <= s;
      bus(1'b1, `REG_CMP_LEVEL_OFS, {20'h0, s + 12'(i)});
      irq_q.push_back(0);
      irq_q.push_back(3);
      if (i == 0) irq_q.push_back(2);
      bus(1'b1, `REG_CTRL_OFS, SCAN_IE | CMP_IE | EVT_EN | START | 32'h3);
      wait_scan;
      rd(`REG_RESULT_OFS, {20'h0, s});
      rd(`REG_CMP_STATUS_OFS, (i == 0) ? 32'h1 : 32'h0);
      bus(1'b1, `REG_CMP_STATUS_OFS, 32'h1);
    end
    bus(1'b1, `REG_CONV_OFS, 32'h1 << `CONV_AUTOCLR_BIT);
    bus(1'b1, `REG_CTRL_OFS, START);
    wait_scan;
    rd(`REG_RESULT_OFS, {20'h0, s});
    rd(`REG_RESULT_OFS, 32'h0);
    bus(1'b1, `REG_CTRL_OFS, GROUP | HW_EN | SCAN_IE | GRPB_IE | EVT_EN);
    irq_q.push_back(0);
    irq_q.push_back(3);
    kick(1'b0);
    wait_scan;
    irq_q.push_back(1);
    kick(1'b1);
    wait_scan;
    bus(1'b1, `REG_CTRL_OFS, GROUP | HW_EN | SCAN_IE | EVT_EN);
    kick(1'b1);
    wait_scan;
    bus(1'b1, `REG_CTRL_OFS, GROUP | HW_EN | SCAN_IE | GRPB_IE);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `REG_GRP_PRIO_OFS, (i == 1) ? 32'h3 : 32'h1);
      irq_q.push_back(0);
      kick(1'b1);
      repeat (6) @(posedge core_clk_i);
      kick(1'b0);
      wait_scan;
      if (i == 1) begin
        irq_q.push_back(1);
        wait_scan;
      end
    end
    bus(1'b1, `REG_CTRL_OFS, GROUP | HW_EN | SCAN_IE | DBL_EN | 32'h3);
    v = 32'($random(seed)) & 32'h0000_0fff;
    sample_val <= v[11:0];
    kick(1'b0);
    wait_scan;
    s = 12'($random(seed));
    sample_val <= s;
    irq_q.push_back(0);
    kick(1'b0);
    wait_scan;
    rd(`REG_RESULT_OFS, v);
    rd(`REG_DUP_OFS, {20'h0, s});
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`REG_CTRL_OFS, `CTRL_RESET);
    rd(`REG_DUP_OFS, 32'h0);
    wrap_up;
  end
endmodule // adc_scan_event_control_tb
`default_nettype wire
